// *** receiver_mode_profile_regs.sv ***
// receiver mode profile register bank for modes 3 (partial) to 6
`default_nettype none
`include "rx_mode_profile_regs.svh"

// Overview of operation
// RULE1 - mode4 enables: splitters bits6-4, channels bits3-0
// RULE2 - mode4 resets to splitter one, pair b, ch4
// RULE3 - mode5 enables reset all set, bit7 zero
// RULE4 - mode6 resets to splitter one, pair a, ch1
// RULE5 - gain words: odd [6:4], even [2:0]
// RULE6 - mode3 to mode5 gains reset to seven
// RULE7 - decode the mode3, mode4, mode5 gain offsets
// RULE8 - enable bits writable, bit 7 read-only
// RULE9 - selected mode drives its stored profile outward
module receiver_mode_profile_regs (
    input  wire logic                                i_clk_sys,
    input  wire logic                                i_nrst,
    input  wire rx_mode_profile_pkg::reg_req_t       i_req,
    input  wire logic [`RMP_MODE_W-1:0]              i_mode,
    output var  logic [`RMP_DATA_W-1:0]              o_rdata,
    output var  logic                                o_rvalid,
    output var  logic                                o_rhit,
    output var  rx_mode_profile_pkg::rx_profile_t    o_profile,
    output var  logic                                o_profile_served,
    output var  logic                                o_gain34_only
);
    import rx_mode_profile_pkg::*;

    // =====================================================================
    // decode helpers
    // =====================================================================

    // offset to bank index; hit low for anything outside the bank
    function automatic logic [`RMP_IDX_W:0] decode_addr(
        input logic [`RMP_ADDR_W-1:0] addr
    );
        logic [`RMP_IDX_W:0] res;
        res = '0;
        case (addr)
            `RMP_MODE3_GAIN34: res = {1'b1, `RMP_IDX_M3_G34}; // [RULE7]
            `RMP_MODE4_EN:     res = {1'b1, `RMP_IDX_M4_EN};
            `RMP_MODE4_GAIN12: res = {1'b1, `RMP_IDX_M4_G12}; // [RULE7]
            `RMP_MODE4_GAIN34: res = {1'b1, `RMP_IDX_M4_G34}; // [RULE7]
            `RMP_MODE5_EN:     res = {1'b1, `RMP_IDX_M5_EN};
            `RMP_MODE5_GAIN12: res = {1'b1, `RMP_IDX_M5_G12}; // [RULE7]
            `RMP_MODE5_GAIN34: res = {1'b1, `RMP_IDX_M5_G34}; // [RULE7]
            `RMP_MODE6_EN:     res = {1'b1, `RMP_IDX_M6_EN};
            `RMP_MODE6_GAIN12: res = {1'b1, `RMP_IDX_M6_G12};
            `RMP_MODE6_GAIN34: res = {1'b1, `RMP_IDX_M6_G34};
            default:           res = '0;
        endcase
        return res;
    endfunction

    // enable words versus gain words
    function automatic logic is_enable_word(input logic [`RMP_IDX_W-1:0] idx);
        return (idx == `RMP_IDX_M4_EN) || (idx == `RMP_IDX_M5_EN) ||
               (idx == `RMP_IDX_M6_EN);
    endfunction

    // writable bits per word; reserved bits never take a write
    function automatic logic [`RMP_DATA_W-1:0] write_mask(
        input logic [`RMP_IDX_W-1:0] idx
    );
        return is_enable_word(idx) ? `RMP_MASK_EN   // [RULE8]
                                   : `RMP_MASK_GAIN; // [RULE5]
    endfunction

    // reset value per word
    function automatic logic [`RMP_DATA_W-1:0] reset_value(
        input logic [`RMP_IDX_W-1:0] idx
    );
        logic [`RMP_DATA_W-1:0] v;
        v = `RMP_RST_GAIN_MAX;                       // [RULE6]
        case (idx)
            `RMP_IDX_M4_EN:  v = `RMP_RST_M4_EN;     // [RULE2]
            `RMP_IDX_M5_EN:  v = `RMP_RST_M5_EN;     // [RULE3]
            `RMP_IDX_M6_EN:  v = `RMP_RST_M6_EN;     // [RULE4]
            `RMP_IDX_M6_G12: v = `RMP_RST_GAIN_M6;
            `RMP_IDX_M6_G34: v = `RMP_RST_GAIN_M6;
            default:         v = `RMP_RST_GAIN_MAX;  // [RULE6]
        endcase
        return v;
    endfunction

    // build the outgoing profile from one enable word and two gain words
    function automatic rx_profile_t build_profile(
        input logic [`RMP_DATA_W-1:0] en,
        input logic [`RMP_DATA_W-1:0] g12,
        input logic [`RMP_DATA_W-1:0] g34
    );
        rx_profile_t p;
        {p.splitter_one_on, p.splitter_pair_a_on, p.splitter_pair_b_on,
         p.channel_on} = en[`RMP_EN_HI:0];                     // [RULE1]
        p.channel1_gain = g12[`RMP_GAIN_ODD_HI:`RMP_GAIN_ODD_LO];   // [RULE5]
        p.channel2_gain = g12[`RMP_GAIN_EVEN_HI:`RMP_GAIN_EVEN_LO];
        p.channel3_gain = g34[`RMP_GAIN_ODD_HI:`RMP_GAIN_ODD_LO];
        p.channel4_gain = g34[`RMP_GAIN_EVEN_HI:`RMP_GAIN_EVEN_LO];
        return p;
    endfunction

    // =====================================================================
    // register storage
    // =====================================================================

    logic [`RMP_DATA_W-1:0] regs_r [`RMP_NUM_REGS];
    logic [`RMP_IDX_W:0]    dec;
    logic                   dec_hit;
    logic [`RMP_IDX_W-1:0]  dec_idx;

    assign dec     = decode_addr(i_req.addr);
    assign dec_hit = dec[`RMP_IDX_W];
    assign dec_idx = dec[`RMP_IDX_W-1:0];

    // one flop group per word; masked write keeps reserved bits at zero
    genvar gi;
    generate
        for (gi = 0; gi < `RMP_NUM_REGS; gi++) begin : g_word
            localparam logic [`RMP_IDX_W-1:0] IDX = `RMP_IDX_W'(gi);
            always_ff @(posedge i_clk_sys or negedge i_nrst) begin
                if (!i_nrst) begin
                    regs_r[gi] <= reset_value(IDX);           // [RULE2]
                end else if (i_req.wr && dec_hit && dec_idx == IDX) begin
                    regs_r[gi] <= i_req.wdata & write_mask(IDX); // [RULE8]
                end
            end
        end
    endgenerate

    // =====================================================================
    // read path
    // =====================================================================

    // registered read; unmapped offsets return zero with hit low so the
    // port logic can tell them apart from a real zero
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata  <= '0;
            o_rvalid <= 1'b0;
            o_rhit   <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            o_rhit   <= i_req.rd && dec_hit;
            if (i_req.rd && dec_hit) begin
                o_rdata <= regs_r[dec_idx];                   // [RULE5]
            end else begin
                o_rdata <= '0;
            end
        end
    end

    // =====================================================================
    // profile output to the receiver
    // =====================================================================

    rx_profile_t profile_nxt;
    logic        served_nxt;
    logic        partial_nxt;

    // mode 3 only owns its channel 3-4 gain word here; the rest of that
    // profile lives elsewhere, so those fields are zero and flagged
    always_comb begin
        profile_nxt = '0;
        served_nxt  = 1'b1;
        partial_nxt = 1'b0;
        case (i_mode)
            `RMP_MODE3: begin
                profile_nxt = build_profile('0, '0,
                                            regs_r[`RMP_IDX_M3_G34]);
                partial_nxt = 1'b1;
            end
            `RMP_MODE4: begin
                profile_nxt = build_profile(regs_r[`RMP_IDX_M4_EN],
                                            regs_r[`RMP_IDX_M4_G12],
                                            regs_r[`RMP_IDX_M4_G34]); // [RULE9]
            end
            `RMP_MODE5: begin
                profile_nxt = build_profile(regs_r[`RMP_IDX_M5_EN],
                                            regs_r[`RMP_IDX_M5_G12],
                                            regs_r[`RMP_IDX_M5_G34]); // [RULE9]
            end
            `RMP_MODE6: begin
                profile_nxt = build_profile(regs_r[`RMP_IDX_M6_EN],
                                            regs_r[`RMP_IDX_M6_G12],
                                            regs_r[`RMP_IDX_M6_G34]); // [RULE9]
            end
            default: begin
                served_nxt = 1'b0;
            end
        endcase
    end

    // registered so the analog controls never see decode glitches
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            o_profile        <= '0;
            o_profile_served <= 1'b0;
            o_gain34_only    <= 1'b0;
        end else begin
            o_profile        <= profile_nxt;                  // [RULE9]
            o_profile_served <= served_nxt;
            o_gain34_only    <= partial_nxt;
        end
    end

endmodule
`default_nettype wire

// *** rx_mode_profile_regs.svh ***
// register offsets, reset values and field positions of the mode profiles
`ifndef RX_MODE_PROFILE_REGS_SVH
`define RX_MODE_PROFILE_REGS_SVH

`define RMP_ADDR_W          10
`define RMP_DATA_W          8
`define RMP_NUM_REGS        10
`define RMP_IDX_W           4

// register offsets
`define RMP_MODE3_GAIN34    10'h04b
`define RMP_MODE4_EN        10'h04c
`define RMP_MODE4_GAIN12    10'h04d
`define RMP_MODE4_GAIN34    10'h04e
`define RMP_MODE5_EN        10'h04f
`define RMP_MODE5_GAIN12    10'h050
`define RMP_MODE5_GAIN34    10'h051
`define RMP_MODE6_EN        10'h052
`define RMP_MODE6_GAIN12    10'h053
`define RMP_MODE6_GAIN34    10'h054

// register indices inside the bank
`define RMP_IDX_M3_G34      4'h0
`define RMP_IDX_M4_EN       4'h1
`define RMP_IDX_M4_G12      4'h2
`define RMP_IDX_M4_G34      4'h3
`define RMP_IDX_M5_EN       4'h4
`define RMP_IDX_M5_G12      4'h5
`define RMP_IDX_M5_G34      4'h6
`define RMP_IDX_M6_EN       4'h7
`define RMP_IDX_M6_G12      4'h8
`define RMP_IDX_M6_G34      4'h9

// reset values
`define RMP_RST_M4_EN       8'h51
`define RMP_RST_M5_EN       8'h7f
`define RMP_RST_M6_EN       8'h68
`define RMP_RST_GAIN_MAX    8'h77
`define RMP_RST_GAIN_M6     8'h44

// writable bits: bit 7 (and bit 3 of gain words) are reserved
`define RMP_MASK_EN         8'h7f
`define RMP_MASK_GAIN       8'h77

// fields
`define RMP_EN_HI           6
`define RMP_GAIN_ODD_HI     6
`define RMP_GAIN_ODD_LO     4
`define RMP_GAIN_EVEN_HI    2
`define RMP_GAIN_EVEN_LO    0

// receiver mode numbers served here
`define RMP_MODE_W          4
`define RMP_MODE3           4'h3
`define RMP_MODE4           4'h4
`define RMP_MODE5           4'h5
`define RMP_MODE6           4'h6

`endif

// *** rx_mode_profile_pkg.sv ***
// types shared by the receiver mode profile bank
`default_nettype none
`include "rx_mode_profile_regs.svh"
package rx_mode_profile_pkg;

    // one register access from the serial control port back end
    typedef struct packed {
        logic                     wr;
        logic                     rd;
        logic [`RMP_ADDR_W-1:0]   addr;
        logic [`RMP_DATA_W-1:0]   wdata;
    } reg_req_t;

    // settings applied to the receiver for the selected mode
    typedef struct packed {
        logic       splitter_one_on;
        logic       splitter_pair_a_on;
        logic       splitter_pair_b_on;
        logic [3:0] channel_on;      // [3]=channel 1 .. [0]=channel 4
        logic [2:0] channel1_gain;
        logic [2:0] channel2_gain;
        logic [2:0] channel3_gain;
        logic [2:0] channel4_gain;
    } rx_profile_t;

endpackage
`default_nettype wire

// *** receiver_mode_profile_regs_sva.sv ***
// checker for the receiver mode profile register bank
`default_nettype none
`include "rx_mode_profile_regs.svh"
module rmp_checker
    import rx_mode_profile_pkg::*;
(
    input wire logic                      i_clk_sys,
    input wire logic                      i_nrst,
    input wire reg_req_t                  i_req,
    input wire logic [`RMP_MODE_W-1:0]    i_mode,
    input wire logic [`RMP_DATA_W-1:0]    o_rdata,
    input wire logic                      o_rvalid,
    input wire logic                      o_rhit,
    input wire rx_profile_t               o_profile,
    input wire logic                      o_profile_served,
    input wire logic                      o_gain34_only
);
    // =========================================================
    // assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    read_answer_a: assert property (i_req.rd |=> o_rvalid)
        else $error("read not answered next cycle");
    no_stray_a: assert property (!i_req.rd |=> !o_rvalid)
        else $error("answer without a read");
    rsvd_top_a: assert property (o_rvalid |-> !o_rdata[7])
        else $error("bit 7 read as one");
    gain_gap_a: assert property (o_rvalid && !($past(i_req.addr) inside
        {10'h04c, 10'h04f, 10'h052}) |-> !o_rdata[3])
        else $error("gain bit 3 read as one");
    map_hit_a: assert property (i_req.rd && i_req.addr inside
        {[10'h04b:10'h054]} |=> o_rhit)
        else $error("mapped read missed");
    miss_zero_a: assert property (i_req.rd && !(i_req.addr inside
        {[10'h04b:10'h054]}) |=> !o_rhit && o_rdata == 8'h00)
        else $error("unmapped read not zero");
    served_a: assert property (i_mode inside {[4'h3:4'h6]}
        |=> o_profile_served)
        else $error("served mode not flagged");
    mode3_part_a: assert property (i_mode == 4'h3 |=> o_gain34_only
        && o_profile.channel_on == 4'h0 && o_profile.channel1_gain == 3'h0)
        else $error("mode 3 profile wrong");
    idle_zero_a: assert property (!(i_mode inside {[4'h3:4'h6]})
        |=> o_profile == '0 && !o_profile_served)
        else $error("unserved mode drives profile");
    hit_c: cover property (o_rvalid && o_rhit);
    miss_c: cover property (o_rvalid && !o_rhit);
    mode3_c: cover property (o_gain34_only);
endmodule
bind receiver_mode_profile_regs rmp_checker i_chk (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req(i_req), .i_mode(i_mode),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_rhit(o_rhit),
    .o_profile(o_profile), .o_profile_served(o_profile_served),
    .o_gain34_only(o_gain34_only));
`default_nettype wire

// *** tb_top.sv ***
// self-checking testbench for the receiver mode profile bank
`default_nettype none
`include "rx_mode_profile_regs.svh"
module tb_top;
    import rx_mode_profile_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk_sys = 1'b0;
    logic        i_nrst = 1'b0;
    reg_req_t    i_req = '0;
    logic [3:0]  i_mode = 4'h0;
    logic [7:0]  o_rdata;
    logic        o_rvalid, o_rhit, o_profile_served, o_gain34_only;
    rx_profile_t o_profile;
    int          fails = 0;
    int          comparisons = 0;
    int          cyc = 0;
    logic [7:0]  rst_v [10] = '{8'h77, 8'h51, 8'h77, 8'h77, 8'h7f,
                                8'h77, 8'h77, 8'h68, 8'h44, 8'h44};
    receiver_mode_profile_regs i_dut (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_req(i_req),
        .i_mode(i_mode), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .o_rhit(o_rhit), .o_profile(o_profile),
        .o_profile_served(o_profile_served),
        .o_gain34_only(o_gain34_only));
    // =========================================================
    // clock and hang guard
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 3000) begin // far beyond the about 140 cycles used
            fails++;
            wrap_up();
        end
    end
    // =========================================================
    // shared tasks
    task automatic chk(input logic [20:0] s, input logic [20:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk_sys);
        i_req <= '0;
    endtask
    // read answers right at the taking edge, for one cycle only
    task automatic rd(input logic [9:0] a, input logic [7:0] e,
                      input logic h);
        @(posedge i_clk_sys);
        i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk_sys);
        i_req <= '0;
        #1;
        chk({o_rvalid, o_rhit, o_rdata}, {1'b1, h, e});
    endtask
    task automatic prof(input logic [3:0] m, input logic [20:0] e);
        @(posedge i_clk_sys);
        i_mode <= m;
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk({o_profile_served, o_gain34_only, o_profile}, e);
    endtask
    // =========================================================
    // scenarios
    task automatic t_reset();
        for (int i = 0; i < 10; i++)
            rd(10'h04b + 10'(i), rst_v[i], 1'b1);
        prof(4'h3, {2'b11, 13'h0, 6'h3f});
        prof(4'h4, {2'b10, 7'h51, 12'hfff});
        prof(4'h5, {2'b10, 7'h7f, 12'hfff});
        prof(4'h6, {2'b10, 7'h68, 12'h924});
        prof(4'h7, 21'h0);
        $display("reset values done");
    endtask
    task automatic t_write();
        logic [7:0] m;
        for (int i = 0; i < 10; i++) begin
            m = (i % 3 == 1) ? 8'h7f : 8'h77; // enable words at idx 1,4,7
            wr(10'h04b + 10'(i), 8'hff);
            rd(10'h04b + 10'(i), m, 1'b1);
            wr(10'h04b + 10'(i), 8'h00);
            rd(10'h04b + 10'(i), 8'h00, 1'b1);
        end
        $display("write masks done");
    endtask
    task automatic t_apply();
        wr(`RMP_MODE4_EN, 8'h2a);
        wr(`RMP_MODE4_GAIN12, 8'h35);
        wr(`RMP_MODE4_GAIN34, 8'h61);
        wr(`RMP_MODE3_GAIN34, 8'h52);
        prof(4'h4, {2'b10, 7'h2a, 3'd3, 3'd5, 3'd6, 3'd1});
        prof(4'h3, {2'b11, 13'h0, 3'd5, 3'd2});
        $display("profile apply done");
    endtask
    task automatic t_unmapped();
        rd(10'h04a, 8'h00, 1'b0);
        wr(10'h055, 8'h3c);
        rd(10'h055, 8'h00, 1'b0);
        $display("unmapped done");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        t_reset();
        t_write();
        t_apply();
        t_unmapped();
        wrap_up();
    end
endmodule
`default_nettype wire
